// >>> msd_dispatch.sv
// Purpose: Decode start inputs and dispatch positioning, origin and run moves
// Assumes: Inputs synchronous to clk_sys; profile generator reports motionDone
// Notes:   APB slave always ready; unmapped addresses answer with pslverr
`timescale 1ns/100ps
`default_nettype none
module msd_dispatch #(
  parameter int NUM_DIRECT = 6,
  parameter int DATA_W     = 6
) (
  input  wire logic              clk_sys,
  input  wire logic              reset,
  input  wire logic              clkEn,
  // APB slave
  input  wire logic [7:0]        paddr,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [31:0]       pwdata,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  // Host start inputs
  input  wire logic [DATA_W-1:0] dataSelect,
  input  wire logic              singleStartInput,
  input  wire logic              sequential_start_input,
  input  wire logic [NUM_DIRECT-1:0] directPositionInput,
  input  wire logic              originReturnInput,
  input  wire logic              forward_run_input,
  input  wire logic              reverse_run_input,
  input  wire logic              sensor_input_a,
  input  wire logic              excitation_timing_signal,
  // Profile generator feedback
  input  wire logic              motionDone,
  // Move commands
  output logic                   moveStart,
  output logic [1:0]             moveKind,
  output logic [DATA_W-1:0]      moveDataNo,
  output logic                   runFwd,
  output logic                   runRvs,
  output logic                   runDecel,
  output logic [DATA_W-1:0]      runDataNo,
  output logic                   runSpeedChange,
  // Origin search settings
  output logic [1:0]             homeMode,
  output logic                   homeDirPos,
  output logic [19:0]            homeSpeed,
  output logic [19:0]            homeAccel,
  output logic [19:0]            homeStartSpeed,
  output logic [23:0]            homeOffset,
  output logic [9:0]             homePushCurrent,
  output logic                   homeQualOk,
  // Status
  output logic                   originReached,
  output logic                   alarmOut
);

  // ==========================================================
  // Registers
  logic              almEn_ff;
  logic [1:0]        mode_ff;
  logic              dir_ff;
  logic              slitEn_ff;
  logic              timEn_ff;
  logic [19:0]       hSpd_ff;
  logic [19:0]       hAcc_ff;
  logic [19:0]       hStrt_ff;
  logic [23:0]       hOfs_ff;
  logic [9:0]        hCur_ff;
  logic [DATA_W-1:0] map_ff [NUM_DIRECT];
  logic              alarm_ff;
  logic              origin_ff;
  logic [DATA_W-1:0] seqNo_ff;
  logic              runDirFwd_ff;
  logic [DATA_W-1:0] runNo_ff;
  logic              spdChg_ff;
  logic              mvStart_ff;
  logic [1:0]        mvKind_ff;
  logic [DATA_W-1:0] mvNo_ff;
  logic              startPrev_ff;
  logic              seqPrev_ff;
  logic              homePrev_ff;
  logic [NUM_DIRECT-1:0] msPrev_ff;
  msd_pkg::msd_state_t state_ff;
  msd_pkg::msd_state_t nxt_state;

  // ==========================================================
  // APB decode
  wire wrEn    = psel & penable & pwrite;
  wire selCfg  = paddr == msd_pkg::OFS_CFG;
  wire selSpd  = paddr == msd_pkg::OFS_HSPD;
  wire selAcc  = paddr == msd_pkg::OFS_HACC;
  wire selStrt = paddr == msd_pkg::OFS_HSTRT;
  wire selOfs  = paddr == msd_pkg::OFS_HOFS;
  wire selCur  = paddr == msd_pkg::OFS_HCUR;
  wire selLo   = paddr == msd_pkg::OFS_MAPLO;
  wire selHi   = paddr == msd_pkg::OFS_MAPHI;
  wire selStat = paddr == msd_pkg::OFS_STAT;
  wire mapped  = selCfg | selSpd | selAcc | selStrt | selOfs | selCur
               | selLo | selHi | selStat;
  wire almClr  = wrEn & selStat & pwdata[msd_pkg::STAT_ALM];

  // Map read words, one byte lane per direct input
  logic [31:0] mapLoWord;
  logic [31:0] mapHiWord;

  // Read data mux
  wire [31:0] cfgWord = {26'h0, timEn_ff, slitEn_ff, dir_ff, mode_ff, almEn_ff};
  wire [31:0] statWord = {18'h0, seqNo_ff, 1'b0, state_ff, 2'h0, origin_ff, alarm_ff};
  assign prdata = selCfg  ? cfgWord :
                  selSpd  ? {12'h0, hSpd_ff} :
                  selAcc  ? {12'h0, hAcc_ff} :
                  selStrt ? {12'h0, hStrt_ff} :
                  selOfs  ? {{8{hOfs_ff[23]}}, hOfs_ff} :
                  selCur  ? {22'h0, hCur_ff} :
                  selLo   ? mapLoWord :
                  selHi   ? mapHiWord :
                  selStat ? statWord : 32'h0;
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~mapped;

  // ==========================================================
  // Configuration registers
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      almEn_ff  <= msd_pkg::RST_ALMEN;
      mode_ff   <= msd_pkg::RST_MODE;
      dir_ff    <= msd_pkg::RST_DIR;
      slitEn_ff <= msd_pkg::RST_SENSOR_INPUT_A;
      timEn_ff  <= msd_pkg::RST_TIM;
    end
    else if (clkEn && wrEn && selCfg)
    begin
      almEn_ff  <= pwdata[msd_pkg::CFG_ALMEN];
      mode_ff   <= pwdata[msd_pkg::CFG_MODE +: 2];
      dir_ff    <= pwdata[msd_pkg::CFG_DIR];
      slitEn_ff <= pwdata[msd_pkg::CFG_SENSOR_INPUT_A];
      timEn_ff  <= pwdata[msd_pkg::CFG_TIM];
    end
  end

  // Origin search numeric settings
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      hSpd_ff  <= msd_pkg::RST_HSPD;
      hAcc_ff  <= msd_pkg::RST_HACC;
      hStrt_ff <= msd_pkg::RST_HSTRT;
      hOfs_ff  <= msd_pkg::RST_HOFS;
      hCur_ff  <= msd_pkg::RST_HCUR;
    end
    else if (clkEn && wrEn)
    begin
      if (selSpd)
        hSpd_ff <= pwdata[19:0];
      if (selAcc)
        hAcc_ff <= pwdata[19:0];
      if (selStrt)
        hStrt_ff <= pwdata[19:0];
      if (selOfs)
        hOfs_ff <= pwdata[23:0];
      if (selCur)
        hCur_ff <= pwdata[9:0];
    end
  end

  // ==========================================================
  // Direct-position maps, one byte lane each
  logic [NUM_DIRECT-1:0] msRise;
  logic [DATA_W-1:0] msNo [NUM_DIRECT+1];
  assign msNo[NUM_DIRECT] = '0;
  assign msRise = directPositionInput & ~msPrev_ff;

  genvar gi;
  generate
    for (gi = 0; gi < NUM_DIRECT; gi++)
    begin : g_map
      localparam int LANE = (gi % 4) * msd_pkg::MAP_LANE;
      wire selMine = (gi < 4) ? selLo : selHi;
      always_ff @(posedge clk_sys)
      begin
        if (reset)
          map_ff[gi] <= DATA_W'(gi);
        else if (clkEn && wrEn && selMine)
          map_ff[gi] <= pwdata[LANE +: DATA_W];
      end
      // Lowest raised input wins
      assign msNo[gi] = msRise[gi] ? map_ff[gi] : msNo[gi+1];
      if (gi < 4)
      begin : g_lo
        assign mapLoWord[LANE +: 8] = {{(8-DATA_W){1'b0}}, map_ff[gi]};
      end
      else
      begin : g_hi
        assign mapHiWord[LANE +: 8] = {{(8-DATA_W){1'b0}}, map_ff[gi]};
      end
    end
  endgenerate
  // Unused upper lanes read as zero; a full word needs no padding
  if (NUM_DIRECT < 4)
  begin : g_lo_pad
    assign mapLoWord[31:8*NUM_DIRECT] = '0;
  end
  if (NUM_DIRECT < 8)
  begin : g_hi_pad
    assign mapHiWord[31:8*(NUM_DIRECT > 4 ? NUM_DIRECT - 4 : 0)] = '0;
  end

  // ==========================================================
  // Start edge detection
  wire startRise = singleStartInput & ~startPrev_ff;
  wire seqRise   = sequential_start_input & ~seqPrev_ff;
  wire homeRise  = originReturnInput & ~homePrev_ff;
  wire anyMs     = |msRise;
  wire posReq    = startRise | seqRise | anyMs;
  wire runOne    = forward_run_input ^ reverse_run_input;
  wire runBoth   = forward_run_input & reverse_run_input;
  wire isIdle    = state_ff == msd_pkg::ST_IDLE;
  // Positioning refused without origin when the alarm is enabled
  wire almHit    = isIdle & ~alarm_ff & ~homeRise & posReq
                 & ~origin_ff & almEn_ff;
  wire launchPos = isIdle & ~alarm_ff & ~homeRise & posReq & ~almHit;
  wire launchHom = isIdle & ~alarm_ff & homeRise;
  wire launchRun = isIdle & ~alarm_ff & ~homeRise & ~posReq & runOne;
  wire sameDir   = forward_run_input == runDirFwd_ff;
  wire resume    = (state_ff == msd_pkg::ST_DECEL) & runOne & sameDir;

  // Move kind and number by priority: single, sequential, direct
  wire [1:0] selKind = startRise ? msd_pkg::MV_SINGLE :
                       seqRise   ? msd_pkg::MV_SEQ : msd_pkg::MV_DIRECT;
  wire [DATA_W-1:0] selNo = startRise ? dataSelect :
                            seqRise   ? seqNo_ff : msNo[0];

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      startPrev_ff <= 1'b0;
      seqPrev_ff   <= 1'b0;
      homePrev_ff  <= 1'b0;
      msPrev_ff    <= '0;
    end
    else if (clkEn)
    begin
      startPrev_ff <= singleStartInput;
      seqPrev_ff   <= sequential_start_input;
      homePrev_ff  <= originReturnInput;
      msPrev_ff    <= directPositionInput;
    end
  end

  // ==========================================================
  // Dispatch state machine
  always_comb
  begin
    nxt_state = state_ff;
    unique case (state_ff)
      msd_pkg::ST_IDLE:
        if (launchHom)
          nxt_state = msd_pkg::ST_HOME;
        else if (launchPos)
          nxt_state = msd_pkg::ST_POS;
        else if (launchRun)
          nxt_state = msd_pkg::ST_CONT;
      msd_pkg::ST_POS, msd_pkg::ST_HOME:
        if (motionDone)
          nxt_state = msd_pkg::ST_IDLE;
      msd_pkg::ST_CONT:
        if (runBoth || !runOne || !sameDir)
          nxt_state = msd_pkg::ST_DECEL;
      msd_pkg::ST_DECEL:
        if (resume)
          nxt_state = msd_pkg::ST_CONT;
        else if (motionDone)
          nxt_state = msd_pkg::ST_IDLE;
      default:
        nxt_state = msd_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
      state_ff <= msd_pkg::ST_IDLE;
    else if (clkEn)
      state_ff <= nxt_state;
  end

  // ==========================================================
  // Move command launch, one pulse per accepted start
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      mvStart_ff <= 1'b0;
      mvKind_ff  <= msd_pkg::MV_SINGLE;
      mvNo_ff    <= '0;
      seqNo_ff   <= '0;
    end
    else if (clkEn)
    begin
      mvStart_ff <= launchPos | launchHom;
      if (launchHom)
        mvKind_ff <= msd_pkg::MV_HOME;
      else if (launchPos)
      begin
        mvKind_ff <= selKind;
        mvNo_ff   <= selNo;
        seqNo_ff  <= selNo + 1'b1;
      end
    end
  end

  // ==========================================================
  // Origin flag and alarm; set wins over software clear
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      origin_ff <= 1'b0;
      alarm_ff  <= 1'b0;
    end
    else if (clkEn)
    begin
      if (launchHom)
        origin_ff <= 1'b0;
      else if (state_ff == msd_pkg::ST_HOME && motionDone)
        origin_ff <= 1'b1;
      if (almHit)
        alarm_ff <= 1'b1;
      else if (almClr)
        alarm_ff <= 1'b0;
    end
  end

  // ==========================================================
  // Continuous run direction and speed tracking
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      runDirFwd_ff <= 1'b1;
      runNo_ff     <= '0;
      spdChg_ff    <= 1'b0;
    end
    else if (clkEn)
    begin
      if (launchRun)
        runDirFwd_ff <= forward_run_input;
      runNo_ff  <= dataSelect;
      spdChg_ff <= (state_ff == msd_pkg::ST_CONT)
                 & (dataSelect != runNo_ff);
    end
  end

  // ==========================================================
  // Outputs
  assign moveStart       = mvStart_ff;
  assign moveKind        = mvKind_ff;
  assign moveDataNo      = mvNo_ff;
  assign runFwd          = (state_ff == msd_pkg::ST_CONT) & runDirFwd_ff;
  assign runRvs          = (state_ff == msd_pkg::ST_CONT) & ~runDirFwd_ff;
  assign runDecel        = state_ff == msd_pkg::ST_DECEL;
  assign runDataNo       = runNo_ff;
  assign runSpeedChange  = spdChg_ff;
  assign homeMode        = mode_ff;
  assign homeDirPos      = dir_ff;
  assign homeSpeed       = hSpd_ff;
  assign homeAccel       = hAcc_ff;
  assign homeStartSpeed  = hStrt_ff;
  assign homeOffset      = hOfs_ff;
  assign homePushCurrent = hCur_ff;
  // Search qualifier from optional sensor_input_a and timing inputs
  assign homeQualOk      = (~slitEn_ff | sensor_input_a)
                         & (~timEn_ff | excitation_timing_signal);
  assign originReached   = origin_ff;
  assign alarmOut        = alarm_ff;

endmodule // msd_dispatch
`default_nettype wire

// >>> msd_pkg.sv
// Purpose: Shared constants and types of the motion start dispatcher
// Assumes: One clock domain, APB register access with 32-bit data
// Notes:   Offsets are byte addresses, one aligned word per register
`default_nettype none
package msd_pkg;
  // ==========================================================
  // Register offsets
  localparam logic [7:0] OFS_CFG    = 8'h00;
  localparam logic [7:0] OFS_HSPD   = 8'h04;
  localparam logic [7:0] OFS_HACC   = 8'h08;
  localparam logic [7:0] OFS_HSTRT  = 8'h0c;
  localparam logic [7:0] OFS_HOFS   = 8'h10;
  localparam logic [7:0] OFS_HCUR   = 8'h14;
  localparam logic [7:0] OFS_MAPLO  = 8'h18;
  localparam logic [7:0] OFS_MAPHI  = 8'h1c;
  localparam logic [7:0] OFS_STAT   = 8'h20;
  // ==========================================================
  // Field positions
  localparam int CFG_ALMEN  = 0;
  localparam int CFG_MODE   = 1;
  localparam int CFG_DIR    = 3;
  localparam int CFG_SENSOR_INPUT_A   = 4;
  localparam int CFG_TIM    = 5;
  localparam int STAT_ALM   = 0;
  localparam int STAT_ORG   = 1;
  localparam int STAT_STATE = 4;
  localparam int STAT_SEQ   = 8;
  localparam int MAP_LANE   = 8;
  // ==========================================================
  // Reset values
  localparam logic       RST_ALMEN = 1'b0;
  localparam logic [1:0] RST_MODE  = 2'h1;
  localparam logic       RST_DIR   = 1'b1;
  localparam logic       RST_SENSOR_INPUT_A  = 1'b0;
  localparam logic       RST_TIM   = 1'b0;
  localparam logic [19:0] RST_HSPD  = 20'h003e8;
  localparam logic [19:0] RST_HACC  = 20'h003e8;
  localparam logic [19:0] RST_HSTRT = 20'h001f4;
  localparam logic [23:0] RST_HOFS  = 24'h000000;
  localparam logic [9:0]  RST_HCUR  = 10'h3e8;
  // ==========================================================
  // Types
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_POS   = 3'b001,
    ST_HOME  = 3'b010,
    ST_CONT  = 3'b011,
    ST_DECEL = 3'b100
  } msd_state_t;
  typedef enum logic [1:0] {
    MV_SINGLE = 2'b00,
    MV_SEQ    = 2'b01,
    MV_DIRECT = 2'b10,
    MV_HOME   = 2'b11
  } msd_move_t;
endpackage
`default_nettype wire

// >>> msd_dispatch_monitor.sv
// Purpose: Port assertions of the motion start dispatcher
// Assumes: clkEn held high, inputs driven on the rising edge
// Notes:   Bound to every msd_dispatch instance
`timescale 1ns/100ps
`default_nettype none
module msd_dispatch_monitor (
  input wire logic       clk_sys,
  input wire logic       reset,
  input wire logic [5:0] dataSelect,
  input wire logic       singleStartInput,
  input wire logic       sequential_start_input,
  input wire logic [5:0] directPositionInput,
  input wire logic       originReturnInput,
  input wire logic       forward_run_input,
  input wire logic       reverse_run_input,
  input wire logic       motionDone,
  input wire logic       moveStart,
  input wire logic [1:0] moveKind,
  input wire logic [5:0] moveDataNo,
  input wire logic       runFwd,
  input wire logic       runRvs,
  input wire logic       runDecel,
  input wire logic [5:0] runDataNo,
  input wire logic       runSpeedChange,
  input wire logic       originReached,
  input wire logic       alarmOut
);
  // ==========================================================
  // Helper state
  logic [8:0] prevIn_ff;
  logic [8:0] curIn;
  logic       anyRise;
  logic       speedCond;
  logic [5:0] seqNo_ff;
  logic       lastFwd_ff;
  // Start edges and speed change condition
  assign curIn     = {singleStartInput, sequential_start_input, originReturnInput,
                      directPositionInput};
  assign anyRise   = |(curIn & ~prevIn_ff);
  assign speedCond = (runFwd || runRvs) && (dataSelect != runDataNo);
  // Previous inputs, expected next sequence number, last run direction
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      prevIn_ff  <= 9'h000;
      seqNo_ff   <= 6'h00;
      lastFwd_ff <= 1'b0;
    end
    else
    begin
      prevIn_ff <= curIn;
      if (moveStart && moveKind != msd_pkg::MV_HOME)
        seqNo_ff <= moveDataNo + 6'h01;
      if (runFwd)
        lastFwd_ff <= 1'b1;
      else if (runRvs)
        lastFwd_ff <= 1'b0;
    end
  end
  // ==========================================================
  // Assertions
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  property p_cause; moveStart |-> $past(anyRise); endproperty
  a_cause: assert property (p_cause) else $error("launch without start edge");
  property p_pulse; moveStart |=> !moveStart; endproperty
  a_pulse: assert property (p_pulse) else $error("launch pulse too long");
  property p_single;
    moveStart && moveKind == msd_pkg::MV_SINGLE |-> moveDataNo == $past(dataSelect);
  endproperty
  a_single: assert property (p_single) else $error("single number wrong");
  property p_seq; moveStart && moveKind == msd_pkg::MV_SEQ |-> moveDataNo == seqNo_ff; endproperty
  a_seq: assert property (p_seq) else $error("sequential number wrong");
  property p_homeclr; moveStart && moveKind == msd_pkg::MV_HOME |=> !originReached; endproperty
  a_homeclr: assert property (p_homeclr) else $error("origin flag kept");
  property p_orgset; $rose(originReached) |-> $past(motionDone); endproperty
  a_orgset: assert property (p_orgset) else $error("origin set early");
  property p_both;
    (runFwd || runRvs) && forward_run_input && reverse_run_input |=> runDecel && !runFwd && !runRvs;
  endproperty
  a_both: assert property (p_both) else $error("both runs not stopping");
  property p_resume;
    runDecel && !motionDone && (lastFwd_ff ? forward_run_input && !reverse_run_input
      : reverse_run_input && !forward_run_input) |=> (lastFwd_ff ? runFwd : runRvs);
  endproperty
  a_resume: assert property (p_resume) else $error("run not resumed");
  property p_speed; runSpeedChange == $past(speedCond); endproperty
  a_speed: assert property (p_speed) else $error("speed change pulse wrong");
  property p_alarm; $rose(alarmOut) |-> $past(anyRise); endproperty
  a_alarm: assert property (p_alarm) else $error("alarm without start");
endmodule // msd_dispatch_monitor
bind msd_dispatch msd_dispatch_monitor mon_u (.*);
`default_nettype wire

// >>> msd_profile_model.sv
// Purpose: Profile generator stand-in reporting motion finished
// Assumes: One clock domain with the dispatcher
// Notes:   slow stretches every move and stop to 20 cycles
`timescale 1ns/100ps
`default_nettype none
module msd_profile_model (
  input  wire logic clk_sys,
  input  wire logic reset,
  input  wire logic slow,
  input  wire logic moveStart,
  input  wire logic runDecel,
  output logic      motionDone
);
  logic [4:0] cnt_ff;
  logic       decel_ff;
  logic       prevDecel_ff;
  // Count down a move or a stop; a resumed run cancels the stop
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      cnt_ff       <= 5'h00;
      decel_ff     <= 1'b0;
      prevDecel_ff <= 1'b0;
      motionDone   <= 1'b0;
    end
    else
    begin
      motionDone   <= 1'b0;
      prevDecel_ff <= runDecel;
      if (moveStart || (runDecel && !prevDecel_ff))
      begin
        cnt_ff   <= slow ? 5'h14 : 5'h02;
        decel_ff <= runDecel;
      end
      else if (cnt_ff == 5'h01)
      begin
        cnt_ff     <= 5'h00;
        motionDone <= !(decel_ff && !runDecel); // Motor stopped
      end
      else if (cnt_ff != 5'h00)
        cnt_ff <= cnt_ff - 5'h01;
    end
  end
endmodule // msd_profile_model
`default_nettype wire

// >>> test_msd_dispatch.sv
// Purpose: Self-checking bench of the motion start dispatcher
// Assumes: clkEn held high; profile model answers motion done
// Notes:   Reset and alarm cases first, then launch table, config and run cases
`timescale 1ns/100ps
`default_nettype none
module test_msd_dispatch;
  typedef struct packed {logic [3:0] code; logic [5:0] sel; logic [1:0] kind; logic [5:0] num;}
    msd_row_t;
  logic clk_sys = 0, reset = 1, clkEn = 1, psel = 0, penable = 0, pwrite = 0, slow = 0;
  logic singleStartInput = 0, sequential_start_input = 0, originReturnInput = 0;
  logic forward_run_input = 0, reverse_run_input = 0;
  logic sensor_input_a = 0, excitation_timing_signal = 0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic [5:0]  dataSelect = 6'h00, directPositionInput = 6'h00, moveDataNo, runDataNo;
  logic        pready, pslverr, moveStart, runFwd, runRvs, runDecel, runSpeedChange, e;
  logic        homeDirPos, homeQualOk, originReached, alarmOut, motionDone;
  logic [1:0]  moveKind, homeMode;
  logic [19:0] homeSpeed, homeAccel, homeStartSpeed;
  logic [23:0] homeOffset;
  logic [9:0]  homePushCurrent;
  int          error_cnt = 0, compares = 0, cyc = 0;
  msd_row_t    rows [7];
  logic [31:0] rv [8];
  msd_dispatch dut_u (.*);
  msd_profile_model prof_u (.clk_sys(clk_sys), .reset(reset), .slow(slow),
    .moveStart(moveStart), .runDecel(runDecel), .motionDone(motionDone));
  // ==========================================================
  // Clock and hang guard
  always #10 clk_sys = ~clk_sys;
  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc == 6000)
    begin
      error_cnt++;
      end_of_test();
    end
  end
  // ==========================================================
  // Tasks
  task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
    compares++;
    if (g !== x)
    begin
      $display("[FAIL] %s expected %h seen %h", nm, x, g);
      error_cnt++;
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk_sys);
    penable <= 1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    r = prdata; e = pslverr;
    psel <= 0; penable <= 0;
  endtask
  task automatic waitOn(input int w);
    int n;
    n = 0;
    while (n < 100 && !((w == 0 && moveStart === 1'b1) || (w == 1 && motionDone === 1'b1)))
    begin
      @(posedge clk_sys);
      n++;
    end
    chk("wait", 1, n < 100);
  endtask
  task automatic launch(input logic [3:0] code, input logic [5:0] sel);
    @(posedge clk_sys);
    dataSelect <= sel;
    singleStartInput <= code == 0;
    sequential_start_input <= code == 1;
    originReturnInput <= code == 8;
    directPositionInput <= (code > 1 && code < 8) ? 6'h01 << (code - 2) : 6'h00;
    waitOn(0);
    {singleStartInput, sequential_start_input, originReturnInput} <= 3'h0;
    directPositionInput <= 6'h00;
  endtask
  task automatic run(input logic f, input logic v, input string nm, input logic [2:0] x);
    forward_run_input <= f; reverse_run_input <= v;
    repeat (2) @(posedge clk_sys);
    chk(nm, x, {runFwd, runRvs, runDecel});
  endtask
  task automatic end_of_test();
    $display("compares %0d error_cnt %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // ==========================================================
  // Main sequence
  initial
  begin
    rows = '{'{8, 0, msd_pkg::MV_HOME, 0}, '{0, 5, msd_pkg::MV_SINGLE, 5},
             '{1, 0, msd_pkg::MV_SEQ, 6}, '{5, 0, msd_pkg::MV_DIRECT, 3},
             '{1, 0, msd_pkg::MV_SEQ, 4}, '{0, 63, msd_pkg::MV_SINGLE, 63},
             '{1, 0, msd_pkg::MV_SEQ, 0}};
    rv = '{32'h0a, 32'h3e8, 32'h3e8, 32'h1f4, 32'h0, 32'h3e8, 32'h03020100, 32'h0504};
    repeat (6) @(posedge clk_sys);
    reset <= 0;
    @(posedge clk_sys);
    chk("outs", 0, {moveStart, runFwd, runRvs, runDecel, originReached, alarmOut});
    chk("mode", 3'h3, {homeMode, homeDirPos});
    chk("hspd", 1000, homeSpeed);
    chk("hacc", 1000, homeAccel);
    chk("hstrt", {20'd500, 10'd1000}, {homeStartSpeed, homePushCurrent});
    chk("offset", 0, homeOffset);
    for (int i = 0; i < 8; i++)
    begin
      apb(0, 8'(i * 4), 0);
      chk("reg", rv[i], r);
    end
    $display("test reset done");
    apb(1, msd_pkg::OFS_CFG, 32'h0b);
    dataSelect <= 6'h02;
    singleStartInput <= 1;
    repeat (3) @(posedge clk_sys);
    chk("alarm", 2'b10, {alarmOut, moveStart});
    singleStartInput <= 0;
    apb(1, msd_pkg::OFS_STAT, 32'h1);
    apb(1, msd_pkg::OFS_CFG, 32'h0a);
    chk("alarmclr", 0, alarmOut);
    apb(0, 8'hfc, 0);
    chk("slverr", 1, e);
    chk("unmapped", 0, r);
    $display("test alarm done");
    foreach (rows[i])
    begin
      launch(rows[i].code, rows[i].sel);
      chk("kind", rows[i].kind, moveKind);
      if (rows[i].code != 8) chk("num", rows[i].num, moveDataNo);
      waitOn(1);
      @(posedge clk_sys);
      if (rows[i].code == 8) chk("origin", 1, originReached);
    end
    $display("test launch done");
    apb(1, msd_pkg::OFS_MAPLO, 32'h0302013f);
    launch(2, 0);
    chk("remap", 63, moveDataNo);
    waitOn(1);
    apb(1, msd_pkg::OFS_CFG, 32'h34);
    apb(1, msd_pkg::OFS_HOFS, 32'h800000);
    apb(0, msd_pkg::OFS_HOFS, 0);
    chk("cfg", 3'h4, {homeMode, homeDirPos});
    chk("offs", 24'h800000, homeOffset);
    chk("offsrd", 32'hff800000, r);
    chk("qual", 0, homeQualOk);
    sensor_input_a <= 1;
    @(posedge clk_sys);
    chk("qual", 0, homeQualOk);
    excitation_timing_signal <= 1;
    @(posedge clk_sys);
    chk("qual", 1, homeQualOk);
    $display("test config done");
    slow <= 1;
    run(1, 0, "fwd", 3'b100);
    dataSelect <= 6'h09;
    repeat (2) @(posedge clk_sys);
    chk("spdchg", 1, runSpeedChange);
    @(posedge clk_sys);
    chk("speed", 9, runDataNo);
    run(0, 0, "decel", 3'b001);
    run(1, 0, "resume", 3'b100);
    run(1, 1, "both", 3'b001);
    slow <= 0;
    run(0, 0, "stop", 3'b001);
    waitOn(1);
    run(0, 1, "rvs", 3'b010);
    run(0, 0, "rvsdecel", 3'b001);
    waitOn(1);
    $display("test run done");
    end_of_test();
  end
endmodule // test_msd_dispatch
`default_nettype wire
